//--- verilog/rhd_desc.sv
// rhd_desc: root hub descriptor A register and the port power it steers.
// assumes requests are synchronous to core_clk and last one cycle each.
`default_nettype none
`timescale 1ns/1ps
// Notes on behaviour
// - port count byte reads 3 or 2
// - port count kept between one and fifteen
// - bit 8 selects ganged or per-port power
// - masked ports obey only per-port commands in per-port mode
// - switching mode ignored while power always on
// - bit 9 disables switching, resets to one
// - bit 10 reads zero, writes ignored
// - bit 11 selects overcurrent reporting, resets one
// - reporting mode honoured only without protect disable
// - bit 12 disables overcurrent protection
// - global power-off write clears power of globally switched ports while bit 9 is clear
module rhd_desc
  import rhd_pkg::*;
#(
  parameter bit THIRD_INSTANCE = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire rhd_req_t req,
  input wire logic [RHD_NPORT-1:0] per_port_power_mask,
  input wire logic [RHD_NPORT-1:0] port_power_on_cmd,
  input wire logic [RHD_NPORT-1:0] port_power_off_cmd,
  input wire logic global_power_on_cmd,
  output logic [31:0] rdata,
  output logic rvalid,
  output logic [RHD_NPORT-1:0] port_power,
  output logic per_port_oc_report,
  output logic global_oc_report
);
  // ===========================================================
  // port count constant
  // clamp to legal range
  function automatic logic [7:0] clamp_ports(input logic [7:0] n);
    if (n < RHD_PORTS_MIN) begin
      return RHD_PORTS_MIN;
    end else if (n > RHD_PORTS_MAX) begin
      return RHD_PORTS_MAX;
    end
    return n;
  endfunction : clamp_ports

  localparam logic [7:0] NPORTS = clamp_ports(THIRD_INSTANCE ? RHD_PORTS_B : RHD_PORTS_A);

  // address decode shared by the write strobes and the read port
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_hit

  rhd_cfg_t cfg_q;
  logic wr_desc;
  logic rd_desc;
  logic gp_off;
  logic [31:0] desc_word;

  // one-cycle strobes decoded straight from the request
  assign wr_desc = req.wr && addr_hit(req.addr, RHD_DESC_A_OFS);
  assign rd_desc = req.rd && addr_hit(req.addr, RHD_DESC_A_OFS);
  assign gp_off = req.wr && addr_hit(req.addr, RHD_STATUS_OFS) && req.wdata[RHD_GPOFF_BIT];

  // ===========================================================
  // writable fields; bit 10 and bits 23:13 have no storage
  // writable mode bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{pot: RHD_POT_RST, oc_off: RHD_OCOFF_RST, oc_mode: RHD_OCMODE_RST,
                 sw_off: RHD_SWOFF_RST, sw_mode: RHD_SWMODE_RST};
    end else if (wr_desc) begin
      cfg_q.sw_mode <= req.wdata[RHD_SWMODE_BIT];
      cfg_q.sw_off <= req.wdata[RHD_SWOFF_BIT];
      cfg_q.oc_mode <= req.wdata[RHD_OCMODE_BIT];
      cfg_q.oc_off <= req.wdata[RHD_OCOFF_BIT];
      // wait time field, held for software
      cfg_q.pot <= req.wdata[RHD_POT_LSB +: 8];
    end
  end

  // read word with zeros in fixed bits
  always_comb begin
    desc_word = 32'h0000_0000;
    desc_word[RHD_CNT_LSB +: 8] = NPORTS;
    desc_word[RHD_SWMODE_BIT] = cfg_q.sw_mode;
    desc_word[RHD_SWOFF_BIT] = cfg_q.sw_off;
    desc_word[RHD_OCMODE_BIT] = cfg_q.oc_mode;
    desc_word[RHD_OCOFF_BIT] = cfg_q.oc_off;
    desc_word[RHD_POT_LSB +: 8] = cfg_q.pot;
  end

  // ===========================================================
  // read port: answer one cycle after the request; status reads zero here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (rd_desc) begin
        rdata <= desc_word;
      end else begin
        rdata <= 32'h0000_0000; // unmapped and write-only words read zero
      end
    end
  end

  // ===========================================================
  // port power state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_power <= '0;
    end else begin
      for (int i = 0; i < RHD_NPORT; i++) begin
        if (cfg_q.sw_off) begin
          port_power[i] <= 1'b1;
        end else if (cfg_q.sw_mode && per_port_power_mask[i]) begin
          // masked port takes per-port commands only
          if (port_power_on_cmd[i]) begin
            port_power[i] <= 1'b1;
          end else if (port_power_off_cmd[i]) begin
            port_power[i] <= 1'b0;
          end
        end else begin
          // global switch; off wins on a tie
          if (gp_off) begin
            port_power[i] <= 1'b0;
          end else if (global_power_on_cmd) begin
            port_power[i] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_port_oc_report <= 1'b0;
      global_oc_report <= 1'b0;
    end else begin
      per_port_oc_report <= !cfg_q.oc_off && cfg_q.oc_mode;
      global_oc_report <= !cfg_q.oc_off && !cfg_q.oc_mode;
    end
  end

  // ===========================================================
  // checks: read word
  a_read_fixed_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    rvalid |-> (rdata[23:13] == 11'h000 && rdata[RHD_CMPD_BIT] == 1'b0))
    else $error("fixed descriptor bits not zero");
  a_port_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_desc |=> rdata[7:0] == NPORTS)
    else $error("port count wrong");
  a_count_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_desc |=> (rdata[7:0] >= RHD_PORTS_MIN && rdata[7:0] <= RHD_PORTS_MAX))
    else $error("port count out of range");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (req.rd && !rd_desc) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // the guard on the previous reset keeps the first edge after release quiet
  a_read_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> rvalid == $past(req.rd))
    else $error("read answer not one cycle after request");

  // checks: stored fields
  a_write_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_desc |=> cfg_q.sw_mode == $past(req.wdata[RHD_SWMODE_BIT]))
    else $error("mode bit not stored");
  a_write_swoff: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_desc |=> cfg_q.sw_off == $past(req.wdata[RHD_SWOFF_BIT]))
    else $error("switching disable not stored");
  a_write_ocmode: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_desc |=> cfg_q.oc_mode == $past(req.wdata[RHD_OCMODE_BIT]))
    else $error("reporting mode not stored");
  a_write_ocoff: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_desc |=> cfg_q.oc_off == $past(req.wdata[RHD_OCOFF_BIT]))
    else $error("protection disable not stored");
  a_write_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_desc |=> cfg_q.pot == $past(req.wdata[RHD_POT_LSB +: 8]))
    else $error("wait time not stored");
  a_hold_fields: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_desc |=> $stable(cfg_q))
    else $error("fields changed without a write");

  // checks: port power
  a_swoff_powered: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(rst_n) && $past(cfg_q.sw_off)) |-> port_power == '1)
    else $error("ports not powered with switching off");
  a_mode_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_q.sw_off && gp_off) |=> port_power == '1)
    else $error("power-off honoured while switching disabled");
  a_masked_port: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg_q.sw_off && cfg_q.sw_mode && per_port_power_mask[0] && port_power[0] && !port_power_off_cmd[0] && gp_off)
      |=> port_power[0])
    else $error("masked port reacted to global off");
  a_per_port_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg_q.sw_off && cfg_q.sw_mode && per_port_power_mask[0] && port_power_on_cmd[0]) |=> port_power[0])
    else $error("masked port ignored its own power-on");
  a_unmasked_port: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg_q.sw_off && cfg_q.sw_mode && !per_port_power_mask[1] && port_power[1] && !gp_off)
      |=> port_power[1])
    else $error("unmasked port reacted to a per-port command");
  a_global_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg_q.sw_off && !cfg_q.sw_mode && gp_off) |=> port_power == '0)
    else $error("global power-off ignored");

  // checks: overcurrent reporting
  a_oc_report: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(cfg_q.oc_off) |-> !(per_port_oc_report || global_oc_report))
    else $error("overcurrent reported with protection off");
  a_oc_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(rst_n) && $past(!cfg_q.oc_off)) |-> per_port_oc_report == $past(cfg_q.oc_mode))
    else $error("reporting mode not followed");
  a_oc_global: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(rst_n) && $past(!cfg_q.oc_off)) |-> global_oc_report == !$past(cfg_q.oc_mode))
    else $error("global reporting not followed");
endmodule : rhd_desc
`default_nettype wire

//--- verilog/rhd_pkg.sv
// rhd_pkg: constants and carrier types for the root hub descriptor A block.
// assumes a 32-bit word register port with byte addresses on a word grid.
`default_nettype none
package rhd_pkg;
  // ===========================================================
  // register map
  localparam logic [7:0] RHD_DESC_A_OFS = 8'h48;
  localparam logic [7:0] RHD_STATUS_OFS = 8'h50;
  // ===========================================================
  // field positions
  localparam int RHD_CNT_LSB = 0;
  localparam int RHD_SWMODE_BIT = 8;
  localparam int RHD_SWOFF_BIT = 9;
  localparam int RHD_CMPD_BIT = 10;
  localparam int RHD_OCMODE_BIT = 11;
  localparam int RHD_OCOFF_BIT = 12;
  localparam int RHD_POT_LSB = 24;
  localparam int RHD_GPOFF_BIT = 0;
  // ===========================================================
  // reset values and port counts
  localparam logic RHD_SWMODE_RST = 1'h0;
  localparam logic RHD_SWOFF_RST = 1'h1;
  localparam logic RHD_OCMODE_RST = 1'h1;
  localparam logic RHD_OCOFF_RST = 1'h0;
  localparam logic [7:0] RHD_POT_RST = 8'h02;
  localparam logic [7:0] RHD_PORTS_A = 8'h03;
  localparam logic [7:0] RHD_PORTS_B = 8'h02;
  localparam logic [7:0] RHD_PORTS_MIN = 8'h01;
  localparam logic [7:0] RHD_PORTS_MAX = 8'h0F;
  localparam int RHD_NPORT = 3;
  // ===========================================================
  // register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rhd_req_t;
  // writable descriptor fields
  typedef struct packed {
    logic [7:0] pot;
    logic oc_off;
    logic oc_mode;
    logic sw_off;
    logic sw_mode;
  } rhd_cfg_t;
endpackage : rhd_pkg
`default_nettype wire

//--- testbench/testbench.sv
// testbench: self-checking bench for the root hub descriptor A block.
// assumes rhd_pkg and rhd_desc are compiled first; one clock, async reset.
`default_nettype none
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %s expected %h seen %h", nm, e, a); end end
module testbench;
  import rhd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  rhd_req_t req = '0;
  logic [RHD_NPORT-1:0] mask = '0, pon = '0, poff = '0;
  logic gon = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rdata_b;
  logic rvalid, per_oc, glb_oc;
  logic [RHD_NPORT-1:0] pwr;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // ==========================================================
  // design, clock and hang guard
  rhd_desc #(.THIRD_INSTANCE(1'b0)) u_rhd_desc (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .per_port_power_mask(mask), .port_power_on_cmd(pon), .port_power_off_cmd(poff),
    .global_power_on_cmd(gon), .rdata(rdata), .rvalid(rvalid), .port_power(pwr),
    .per_port_oc_report(per_oc), .global_oc_report(glb_oc));
  // third controller flavour shares the request; only its read word is judged
  rhd_desc #(.THIRD_INSTANCE(1'b1)) u_rhd_desc_third (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .per_port_power_mask(mask), .port_power_on_cmd(pon), .port_power_off_cmd(poff),
    .global_power_on_cmd(gon), .rdata(rdata_b), .rvalid(), .port_power(),
    .per_port_oc_report(), .global_oc_report());
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // the whole run is about sixty cycles, so 2000 means a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================================
  // bus and command tasks; each returns once the effect is visible
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk) req <= '0;
    @(posedge core_clk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge core_clk) req <= '0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic cmd(input logic [2:0] on, input logic [2:0] off, input logic g);
    @(posedge core_clk) begin pon <= on; poff <= off; gon <= g; end
    @(posedge core_clk) begin pon <= '0; poff <= '0; gon <= 1'b0; end
    @(posedge core_clk) #1;
  endtask : cmd
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(RHD_DESC_A_OFS, {RHD_POT_RST, 11'h0, RHD_OCOFF_RST, RHD_OCMODE_RST, 1'b0, RHD_SWOFF_RST,
       RHD_SWMODE_RST, RHD_PORTS_A});
    `CHK("rdata_b", RHD_PORTS_B, rdata_b[7:0])
    `CHK("pwr", 3'h7, pwr)
    `CHK("per_oc", 1'b1, per_oc)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_regs();
    wr(RHD_DESC_A_OFS, 32'hFFFFFFFF);
    rd(RHD_DESC_A_OFS, 32'hFF001B03);
    wr(RHD_DESC_A_OFS, 32'h00000000);
    rd(RHD_DESC_A_OFS, 32'h00000003);
    rd(8'h4C, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_oc();
    wr(RHD_DESC_A_OFS, 32'h02000000);
    `CHK("glb_oc", 1'b1, glb_oc)
    `CHK("per_oc", 1'b0, per_oc)
    wr(RHD_DESC_A_OFS, 32'h02001800);
    `CHK("glb_oc", 1'b0, glb_oc)
    `CHK("per_oc", 1'b0, per_oc)
    $display("t_oc done");
  endtask : t_oc
  task automatic t_power();
    wr(RHD_DESC_A_OFS, 32'h02000000);
    wr(RHD_STATUS_OFS, 32'h1);
    `CHK("pwr", 3'h0, pwr)
    wr(RHD_STATUS_OFS, 32'h0);
    cmd(3'h0, 3'h0, 1'b1);
    `CHK("pwr", 3'h7, pwr)
    // switching disabled: per-port off must not bite
    wr(RHD_DESC_A_OFS, 32'h02000300);
    mask <= 3'h7;
    cmd(3'h0, 3'h7, 1'b0);
    `CHK("pwr", 3'h7, pwr)
    // per-port mode, only port 0 masked
    wr(RHD_DESC_A_OFS, 32'h02000100);
    mask <= 3'h1;
    wr(RHD_STATUS_OFS, 32'h1);
    `CHK("pwr", 3'h1, pwr)
    cmd(3'h0, 3'h1, 1'b0);
    `CHK("pwr", 3'h0, pwr)
    cmd(3'h7, 3'h0, 1'b0);
    `CHK("pwr", 3'h1, pwr)
    cmd(3'h0, 3'h0, 1'b1);
    `CHK("pwr", 3'h7, pwr)
    $display("t_power done");
  endtask : t_power
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk) #1;
    t_reset();
    t_regs();
    t_oc();
    t_power();
    test_done();
  end
endmodule : testbench
`default_nettype wire
